// ==== shared/fws_params.svh ====
// constants of the flash write-status host controller
//
// Behaviour
// - host uses toggle one alone for done and toggle two alone for sector selection
// - host reads status twice in a row; unchanged toggle means operation done
// - toggling with fail bit high: recheck; still toggling means failure
// - host restarts the double read whenever it resumes interrupted polling
// - after any failure the host writes the reset command
// - host may skip the window bit only if extra sectors follow within 50 us
// - host checks window bit before and after each extra sector erase command
// - host reads status at the program address or an erase-selected sector
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

// ----------------------------------------
// software registers
// ----------------------------------------
`define FWS_R_CTRL 4'h0
`define FWS_R_ADDR 4'h1
`define FWS_R_DATA 4'h2
`define FWS_R_STAT 4'h3
`define FWS_R_LAST 4'h4

// ----------------------------------------
// operation codes written to control
// ----------------------------------------
`define FWS_OP_STOP 4'h0
`define FWS_OP_PROG 4'h1
`define FWS_OP_SERASE 4'h2
`define FWS_OP_CERASE 4'h3
`define FWS_OP_SADD 4'h4
`define FWS_OP_SUSP 4'h5
`define FWS_OP_RESUME 4'h6
`define FWS_OP_RESET 4'h7
`define FWS_OP_POLL 4'h8

// ----------------------------------------
// flash command words, byte mode
// ----------------------------------------
`define FWS_AW 20
`define FWS_A_UNLK1 20'h00aaa
`define FWS_A_UNLK2 20'h00555
`define FWS_D_UNLK1 8'haa
`define FWS_D_UNLK2 8'h55
`define FWS_D_PROG 8'ha0
`define FWS_D_ERASE 8'h80
`define FWS_D_SECT 8'h30
`define FWS_D_CHIP 8'h10
`define FWS_D_SUSP 8'hb0
`define FWS_D_RESUM 8'h30
`define FWS_D_RST 8'hf0

// ----------------------------------------
// status byte bit positions
// ----------------------------------------
`define FWS_B_TOG1 6
`define FWS_B_FAIL 5
`define FWS_B_WIN 3
`define FWS_B_TOG2 2

// ----------------------------------------
// timing
// ----------------------------------------
`define FWS_CLK_NS 50
`define FWS_T_WE_NS 100
`define FWS_T_ACC_NS 70
`define FWS_WE_CYC 3'(((`FWS_T_WE_NS) + (`FWS_CLK_NS) - 1) / (`FWS_CLK_NS))
`define FWS_RD_CYC 3'((((`FWS_T_ACC_NS) + (`FWS_CLK_NS) - 1) / (`FWS_CLK_NS)) + 2)

`endif

// ==== shared/fws_pkg.sv ====
// types of the flash write-status host controller
`include "fws_params.svh"

package fws_pkg;

	typedef enum logic [2:0] {S_IDLE, S_WSET, S_WLOW, S_RLOW, S_GAP} fws_state_t;

	typedef enum logic [2:0] {PH_PRE, PH_CMD, PH_POST, PH_P1, PH_P2, PH_P3, PH_RST} fws_ph_t;

	typedef struct packed {
		logic [`FWS_AW-1:0] addr;
		logic [7:0] dq;
		logic dq_oe;
		logic we_n;
		logic oe_n;
		logic ce_n;
	} fws_pins_t;

	typedef struct packed {
		fws_state_t state;
		fws_ph_t ph;
		logic [3:0] op;
		logic [2:0] step;
		logic [2:0] cnt;
		fws_pins_t pins;
		logic [7:0] rd;
		logic [7:0] prev;
		logic [`FWS_AW-1:0] areg;
		logic [7:0] dreg;
		logic busy;
		logic done;
		logic fail;
		logic rej;
		logic win;
		logic pre_win;
		logic sel;
		logic susp;
		logic [1:0] nrd;
	} fws_st_t;

endpackage : fws_pkg

// ==== src/fws_host.sv ====
// host controller that issues flash commands and polls write status
`timescale 1ns/1ps
`default_nettype none
`include "fws_params.svh"

module fws_host (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// software register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// flash pins
	output fws_pkg::fws_pins_t pins,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_in
);
	import fws_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] dq_m;
	logic [7:0] dq_s;
	logic rb_m;
	logic rb_s;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_m <= 8'h00;
			dq_s <= 8'h00;
			rb_m <= 1'b1;
			rb_s <= 1'b1;
		end
		else
		begin
			dq_m <= dq_in;
			dq_s <= dq_m;
			rb_m <= ready_busy_in;
			rb_s <= rb_m;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	localparam fws_st_t ST_RST = '{state: S_IDLE, ph: PH_P1,
		pins: '{addr: '0, dq: 8'h00, dq_oe: 1'b0, we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1},
		default: '0};

	function automatic logic [27:0] cmd_word(input logic [3:0] op, input logic [2:0] step,
		input logic [19:0] a, input logic [7:0] d);
		case (op)
			`FWS_OP_SADD: return {a, `FWS_D_SECT};
			`FWS_OP_SUSP: return {20'h00000, `FWS_D_SUSP};
			`FWS_OP_RESUME: return {20'h00000, `FWS_D_RESUM};
			`FWS_OP_RESET: return {20'h00000, `FWS_D_RST};
			default:
			begin
				case (step)
					3'd0: return {`FWS_A_UNLK1, `FWS_D_UNLK1};
					3'd1: return {`FWS_A_UNLK2, `FWS_D_UNLK2};
					3'd2: return {`FWS_A_UNLK1, (op == `FWS_OP_PROG) ? `FWS_D_PROG : `FWS_D_ERASE};
					3'd3: return (op == `FWS_OP_PROG) ? {a, d} : {`FWS_A_UNLK1, `FWS_D_UNLK1};
					3'd4: return {`FWS_A_UNLK2, `FWS_D_UNLK2};
					default: return (op == `FWS_OP_SERASE) ? {a, `FWS_D_SECT} : {`FWS_A_UNLK1, `FWS_D_CHIP};
				endcase
			end
		endcase
	endfunction : cmd_word

	function automatic logic [2:0] last_step(input logic [3:0] op);
		case (op)
			`FWS_OP_PROG: return 3'd3;
			`FWS_OP_SERASE, `FWS_OP_CERASE: return 3'd5;
			default: return 3'd0;
		endcase
	endfunction : last_step

	function automatic fws_st_t go_wr(input fws_st_t s, input logic [27:0] w);
		s.state = S_WSET;
		s.pins.addr = w[27:8];
		s.pins.dq = w[7:0];
		s.pins.dq_oe = 1'b1;
		return s;
	endfunction : go_wr

	// reads at held address: program address or erase sector
	function automatic fws_st_t go_rd(input fws_st_t s, input fws_ph_t ph);
		s.state = S_RLOW;
		s.ph = ph;
		s.cnt = 3'd0;
		s.pins.addr = s.areg;
		s.pins.dq_oe = 1'b0;
		s.pins.oe_n = 1'b0;
		return s;
	endfunction : go_rd

	function automatic fws_st_t finish(input fws_st_t s, input logic ok);
		s.state = S_IDLE;
		s.busy = 1'b0;
		s.done = ok;
		s.fail = !ok;
		s.pins.dq_oe = 1'b0;
		s.pins.ce_n = 1'b1;
		if (ok && s.op == `FWS_OP_SUSP)
			s.susp = 1'b1;
		return s;
	endfunction : finish

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	fws_st_t q;
	fws_st_t next_q;
	logic toggled;
	logic ctrl_wr;

	assign pins = q.pins;
	assign toggled = q.rd[`FWS_B_TOG1] != q.prev[`FWS_B_TOG1];
	assign ctrl_wr = wr && addr == `FWS_R_CTRL;

	always_comb
	begin
		next_q = q;
		case (q.state)
			S_IDLE:
				next_q.state = S_IDLE;
			S_WSET:
			begin
				next_q.pins.we_n = 1'b0;
				next_q.cnt = 3'd0;
				next_q.state = S_WLOW;
			end
			S_WLOW:
			begin
				if (q.cnt == `FWS_WE_CYC - 3'd1)
				begin
					next_q.pins.we_n = 1'b1;
					next_q.state = S_GAP;
				end
				else
					next_q.cnt = q.cnt + 3'd1;
			end
			S_RLOW:
			begin
				// oe held low long enough to cover access plus the two sync stages
				if (q.cnt == `FWS_RD_CYC - 3'd1)
				begin
					next_q.rd = dq_s;
					next_q.pins.oe_n = 1'b1;
					next_q.state = S_GAP;
					if (q.ph >= PH_P1 && q.nrd != 2'd3)
						next_q.nrd = q.nrd + 2'd1;
				end
				else
					next_q.cnt = q.cnt + 3'd1;
			end
			S_GAP:
			begin
				case (q.ph)
					PH_PRE:
					begin
						next_q.pre_win = q.rd[`FWS_B_WIN];
						next_q.ph = PH_CMD;
						next_q = go_wr(next_q, cmd_word(q.op, 3'd0, q.areg, q.dreg));
					end
					PH_CMD:
					begin
						if (q.step != last_step(q.op))
						begin
							next_q.step = q.step + 3'd1;
							next_q = go_wr(next_q, cmd_word(q.op, next_q.step, q.areg, q.dreg));
						end
						else if (q.op == `FWS_OP_RESET)
							next_q = finish(next_q, 1'b1);
						else if (q.op == `FWS_OP_SERASE || q.op == `FWS_OP_CERASE
							|| q.op == `FWS_OP_SADD)
							next_q = go_rd(next_q, PH_POST);
						else
							next_q = go_rd(next_q, PH_P1);
					end
					PH_POST:
					begin
						// window bit always read, never skipped
						next_q.win = q.rd[`FWS_B_WIN];
						// window high before or after: sector may be rejected
						if (q.op == `FWS_OP_SADD)
							next_q.rej = q.pre_win | q.rd[`FWS_B_WIN];
						next_q = go_rd(next_q, PH_P1);
					end
					PH_P1:
					begin
						next_q.prev = q.rd;
						next_q = go_rd(next_q, PH_P2);
					end
					PH_P2:
					begin
						// toggle two marks an erase-selected sector
						next_q.sel = q.rd[`FWS_B_TOG2] != q.prev[`FWS_B_TOG2];
						next_q.prev = q.rd;
						// two reads with equal toggle bit mean done
						if (!toggled)
							next_q = finish(next_q, 1'b1);
						// toggling with fail bit: one more read decides
						else if (q.rd[`FWS_B_FAIL])
							next_q = go_rd(next_q, PH_P3);
						else
							next_q = go_rd(next_q, PH_P2);
					end
					PH_P3:
					begin
						if (!toggled)
							next_q = finish(next_q, 1'b1);
						else
						begin
							// failure is followed by the reset command
							next_q.ph = PH_RST;
							next_q = go_wr(next_q, {20'h00000, `FWS_D_RST});
						end
					end
					default:
						next_q = finish(next_q, 1'b0);
				endcase
			end
			default:
				next_q = ST_RST;
		endcase
		if (wr && !q.busy && addr == `FWS_R_ADDR)
			next_q.areg = wdata[19:0];
		if (wr && !q.busy && addr == `FWS_R_DATA)
			next_q.dreg = wdata[7:0];
		// stopping drops progress; a later poll starts from the first read
		if (ctrl_wr && q.busy && wdata[3:0] == `FWS_OP_STOP)
		begin
			next_q = finish(next_q, 1'b0);
			next_q.fail = 1'b0;
			next_q.pins.oe_n = 1'b1;
			next_q.pins.we_n = 1'b1;
		end
		else if (ctrl_wr && !q.busy && wdata[3:0] != `FWS_OP_STOP && wdata[3:0] <= `FWS_OP_POLL)
		begin
			next_q.op = wdata[3:0];
			next_q.busy = 1'b1;
			next_q.done = 1'b0;
			next_q.fail = 1'b0;
			next_q.step = 3'd0;
			next_q.nrd = 2'd0;
			next_q.pins.ce_n = 1'b0;
			if (wdata[3:0] == `FWS_OP_RESUME || wdata[3:0] == `FWS_OP_RESET)
				next_q.susp = 1'b0;
			if (wdata[3:0] == `FWS_OP_SADD)
				next_q.rej = 1'b0;
			if (wdata[3:0] == `FWS_OP_POLL)
				next_q = go_rd(next_q, PH_P1);
			else if (wdata[3:0] == `FWS_OP_SADD)
				next_q = go_rd(next_q, PH_PRE);
			else
			begin
				next_q.ph = PH_CMD;
				next_q = go_wr(next_q, cmd_word(wdata[3:0], 3'd0, next_q.areg, next_q.dreg));
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= ST_RST;
		else
			q <= next_q;
	end

	// ----------------------------------------
	// register read-back
	// ----------------------------------------
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = 32'h00000000;
		if (rd)
		begin
			case (addr)
				`FWS_R_CTRL: next_rdata = {28'h0000000, q.op};
				`FWS_R_ADDR: next_rdata = {12'h000, q.areg};
				`FWS_R_DATA: next_rdata = {24'h000000, q.dreg};
				`FWS_R_STAT: next_rdata = {24'h000000, rb_s, q.susp, q.sel, q.win,
					q.rej, q.fail, q.done, q.busy};
				`FWS_R_LAST: next_rdata = {24'h000000, q.rd};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 32'h00000000;
		else
			rdata <= next_rdata;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_read_addr: assert property ($fell(q.pins.oe_n) |-> q.pins.addr == q.areg && !q.pins.dq_oe)
		else $error("status read not at held address");
	chk_two_reads: assert property ($rose(q.done) && q.op != `FWS_OP_RESET |-> q.nrd >= 2'd2)
		else $error("done without two polling reads");
	chk_fail_recheck: assert property ($rose(q.fail) |-> q.nrd == 2'd3)
		else $error("failure without recheck read");
	chk_fail_reset: assert property ($rose(q.fail) |-> q.pins.dq == `FWS_D_RST && $past(q.state) == S_GAP)
		else $error("failure not preceded by reset command");
	chk_stop_idle: assert property (ctrl_wr && q.busy && wdata[3:0] == `FWS_OP_STOP |=> !q.busy && q.pins.ce_n && q.pins.oe_n)
		else $error("stop did not end polling");
	chk_reject_sadd: assert property ($rose(q.rej) |-> q.op == `FWS_OP_SADD && q.ph == PH_P1)
		else $error("reject flag outside extra sector erase");
	chk_we_pulse: assert property ($fell(q.pins.we_n) |-> q.pins.dq_oe ##1 !q.pins.we_n ##1 q.pins.we_n)
		else $error("write strobe width wrong");
	// a stop may cut a read short, so only reads that end while busy are timed
	chk_oe_pulse: assert property ($rose(q.pins.oe_n) && q.busy
		|-> !$past(q.pins.oe_n, 4) && $past(q.pins.oe_n, 5))
		else $error("read strobe width wrong");
	chk_no_fight: assert property (!(q.pins.dq_oe && !q.pins.oe_n))
		else $error("data driven during read");

endmodule : fws_host
`default_nettype wire

// ==== verification/fws_flash_model.sv ====
// behavioural flash device answering the host's command and status cycles
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model (
	// flash pins from the host and the read count set by the bench
	input wire fws_pkg::fws_pins_t pins,
	input wire logic [7:0] reads_needed,
	// answers to the host
	output logic [7:0] dq_out,
	output logic ready_busy
);
	import fws_pkg::*;
	logic [7:0] mem [0:15];
	logic [7:0] last_wr, last_rd, pd, left, wleft, stat;
	logic [3:0] sa;
	logic [15:0] prot;
	logic busy, erase, susp, halt, fail, win, tog1, tog2, prog_next, got_rst;

	task automatic idle_all();
		busy = 0;
		erase = 0;
		susp = 0;
		halt = 0;
		fail = 0;
		win = 0;
		prog_next = 0;
	endtask : idle_all

	initial
	begin
		foreach (mem[i]) mem[i] = 8'hff;
		{last_wr, last_rd, pd, left, wleft, sa, tog1, tog2, got_rst} = '0;
		prot = '0;
		idle_all();
	end

	assign stat = {erase ? susp : ~pd[7], tog1, fail, 1'b0, win, tog2, 2'b00};
	// status replaces data while busy; released bus shows inverse of last
	assign dq_out = (!pins.oe_n && !pins.ce_n) ? (busy ? stat : mem[pins.addr[3:0]]) : ~last_rd;
	// open drain with pull-up, low only while working
	assign ready_busy = !(busy && !susp);

	// commands take effect at the write strobe rise
	always @(posedge pins.we_n)
	begin
		if (prog_next)
		begin
			prog_next = 0;
			busy = 1;
			pd = pins.dq;
			// protected target: short busy spell, nothing written
			left = prot[pins.addr[3:0]] ? 8'h01 : reads_needed;
			halt = !prot[pins.addr[3:0]] && |(pins.dq & ~mem[pins.addr[3:0]]);
			if (!halt && !prot[pins.addr[3:0]])
				mem[pins.addr[3:0]] = mem[pins.addr[3:0]] & pins.dq;
		end
		else if (pins.dq == 8'hf0)
		begin
			idle_all();
			got_rst = 1;
		end
		else if (pins.dq == 8'hb0 && erase)
			susp = 1;
		else if (pins.dq == 8'h30 && susp)
			susp = 0;
		else if (win)
			last_wr = 8'h00;
		else if (pins.dq == 8'ha0 && last_wr == 8'h55)
			prog_next = 1;
		else if ((pins.dq == 8'h30 && (last_wr == 8'h55 || erase)) ||
			(pins.dq == 8'h10 && last_wr == 8'h55))
		begin
			busy = 1;
			erase = 1;
			left = reads_needed;
			wleft = 8'h02;
			sa = pins.addr[3:0];
		end
		last_wr = pins.dq;
	end

	// each read while busy and not suspended advances the embedded work once the erase accept window has run out
	always @(negedge pins.oe_n)
	begin
		if (busy && !pins.ce_n)
		begin
			if (!susp)
				tog1 = ~tog1;
			if (erase && pins.addr[3:0] == sa)
				tog2 = ~tog2;
			if (erase && wleft != 0)
				wleft = wleft - 1;
			win = erase && wleft == 0;
			if (!susp && !(erase && wleft != 0))
			begin
				if (left != 0)
					left = left - 1;
				else if (halt)
					fail = 1;
				else
				begin
					if (erase && !prot[sa])
						mem[sa] = 8'hff;
					idle_all();
				end
			end
		end
		last_rd = busy ? stat : mem[pins.addr[3:0]];
	end
endmodule : fws_flash_model
`default_nettype wire

// ==== verification/test_flash_write_status_reporting.sv ====
// self-checking bench for the flash write-status host controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_write_status_reporting;
	import fws_pkg::*;
	logic clk, rst_n, wr, rd, ready_busy_in;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, s;
	logic [7:0] dq_in, reads_needed;
	fws_pins_t pins;
	int bad_count, total_checks, cyc;
	localparam int poll_max = 4000;

	fws_host DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pins(pins), .dq_in(dq_in), .ready_busy_in(ready_busy_in));
	fws_flash_model flash (.pins(pins), .reads_needed(reads_needed), .dq_out(dq_in),
		.ready_busy(ready_busy_in));

	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	// hang guard, well above the longest slow erase
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	// start an op, then read status until busy drops or the read budget is spent
	task automatic run_op(input logic [3:0] op, input int reads);
		int n;
		wr_reg(4'h0, {28'h0, op});
		n = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && n < reads)
		begin
			rd_reg(4'h3, s);
			n++;
		end
		if (reads == poll_max)
			check("busy after op", 32'h0, s[0]);
	endtask : run_op

	task automatic t_regs();
		rd_reg(4'h3, s);
		check("status after reset", 32'h80, s);
		wr_reg(4'h9, 32'hffff_ffff);
		rd_reg(4'h9, s);
		check("unmapped read", 32'h0, s);
	endtask : t_regs

	task automatic t_program();
		reads_needed <= 8'h03;
		wr_reg(4'h1, 32'h1);
		wr_reg(4'h2, 32'h0f);
		run_op(4'h1, poll_max);
		check("program status", 32'h2, s[2:0]);
		check("programmed byte", 32'h0f, flash.mem[1]);
		run_op(4'h8, poll_max);
		rd_reg(4'h4, s);
		check("array after program", 32'h0f, s[7:0]);
	endtask : t_program

	task automatic t_fail();
		flash.got_rst = 0;
		wr_reg(4'h2, 32'hf0);
		run_op(4'h1, poll_max);
		check("fail status", 32'h4, s[2:0]);
		check("reset after fail", 32'h1, flash.got_rst);
		check("byte kept", 32'h0f, flash.mem[1]);
	endtask : t_fail

	task automatic t_window();
		reads_needed <= 8'h28;
		flash.mem[2] = 8'h00;
		wr_reg(4'h1, 32'h2);
		// let the erase run past its accept window, then stop polling
		run_op(4'h2, 30);
		wr_reg(4'h0, 32'h0);
		run_op(4'h4, poll_max);
		check("extra sector refused", 32'h1, s[3]);
		check("window closed", 32'h1, s[4]);
		run_op(4'h8, poll_max);
		check("erase done", 32'h1, s[1]);
		check("sector erased", 32'hff, flash.mem[2]);
	endtask : t_window

	task automatic t_suspend();
		reads_needed <= 8'h96;
		flash.mem[3] = 8'h00;
		wr_reg(4'h1, 32'h3);
		run_op(4'h2, 30);
		wr_reg(4'h0, 32'h0);
		run_op(4'h5, poll_max);
		check("suspended ready", 32'h3, {s[7], s[6]});
		check("erase sector selected", 32'h1, s[5]);
		run_op(4'h6, poll_max);
		run_op(4'h8, poll_max);
		check("resumed done", 32'h1, {s[6], s[1]});
		check("sector erased", 32'hff, flash.mem[3]);
	endtask : t_suspend

	task automatic t_protect();
		reads_needed <= 8'h04;
		flash.prot[5] = 1'b1;
		wr_reg(4'h1, 32'h5);
		wr_reg(4'h2, 32'h00);
		run_op(4'h1, poll_max);
		check("protected program status", 32'h2, s[2:0]);
		check("protected byte kept", 32'hff, flash.mem[5]);
		flash.mem[5] = 8'h00;
		run_op(4'h2, poll_max);
		check("protected erase status", 32'h2, s[2:0]);
		check("protected sector kept", 32'h00, flash.mem[5]);
	endtask : t_protect

	task automatic t_chip_reset();
		reads_needed <= 8'h04;
		flash.got_rst = 0;
		run_op(4'h3, poll_max);
		check("chip erase done", 32'h2, s[2:0]);
		run_op(4'h7, poll_max);
		check("reset sent", 32'h1, flash.got_rst);
	endtask : t_chip_reset

	initial
	begin
		{rst_n, wr, rd, addr, wdata, bad_count, total_checks, cyc} = '0;
		reads_needed = 8'h04;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_program();
		t_fail();
		t_window();
		t_suspend();
		t_protect();
		t_chip_reset();
		complete_run();
	end
endmodule : test_flash_write_status_reporting
`default_nettype wire
